/* src/sto_sequencer.sv */
// safe torque off sequencer: filters both channels, checks discrepancy,
// sequences output stage, holding brake and setpoint release
// assumes channel and enable inputs already synchronous to core_clk
// Overview of operation
// - both channels are handled by identical logic, order irrelevant
// - mismatch up to 100 ms is tolerated, longer raises error
// - removal while output stage active raises error
// - output stage goes inactive within 5 ms of removal
// - channel return recognised within 1 ms, typically 0.6 ms
// - internal sequence adds at most 10 ms of delay
// - setpoint withheld until brake release delay elapsed
// - brake switch-off delay applied before stage disabled by enable drop
// - off-going test pulses up to 1.5 ms are ignored
// - output stage active about 6 ms after enable plus start delay
`timescale 1ns/1ps
module sto_sequencer #(
   parameter int DISCREP_CYC  = sto_pkg::DISCREP_CYC,
   parameter int PULSE_CYC    = sto_pkg::PULSE_CYC,
   parameter int ON_CYC       = sto_pkg::ON_CYC,
   parameter int STAGE_ON_CYC = sto_pkg::STAGE_ON_CYC
) (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     resetn,
   // safety channels and enable
   input  wire logic                     torque_off_channel_a,
   input  wire logic                     torque_off_channel_b,
   input  wire logic                     drive_enable_input,
   // brake delays in cycles
   input  wire logic [sto_pkg::CNT_W-1:0] brake_release_cyc,
   input  wire logic [sto_pkg::CNT_W-1:0] brake_engage_cyc,
   // outputs
   output logic                          stage_active,
   output logic                          brake_released,
   output logic                          setpoint_enable,
   output logic                          discrepancy_error,
   output logic                          removal_error
);
   // ***********************************************
   // declarations
   // ***********************************************
   logic [1:0]                chan_in;
   logic [1:0]                chan_reg;
   logic [sto_pkg::CNT_W-1:0] flt_cnt_reg [2];
   logic [sto_pkg::CNT_W-1:0] disc_cnt_reg;
   logic [sto_pkg::CNT_W-1:0] seq_cnt_reg;
   sto_pkg::sto_state_t       state_reg;
   logic                      both_on;
   logic                      any_off;
   logic                      stage_reg;
   logic                      brake_reg;
   logic                      setp_reg;
   logic                      disc_err_reg;
   logic                      rem_err_reg;

   // limits cut to counter width once, so every compare is like for like
   localparam logic [sto_pkg::CNT_W-1:0] PULSE_LIM   =
      sto_pkg::CNT_W'(PULSE_CYC);
   localparam logic [sto_pkg::CNT_W-1:0] ON_LIM      =
      sto_pkg::CNT_W'(ON_CYC - 1);
   localparam logic [sto_pkg::CNT_W-1:0] STAGE_LIM   =
      sto_pkg::CNT_W'(STAGE_ON_CYC - 1);
   localparam logic [sto_pkg::CNT_W-1:0] DISCREP_LIM =
      sto_pkg::CNT_W'(DISCREP_CYC);

   // ***********************************************
   // helpers
   // ***********************************************
   // every delay in this block is a counter compared with its limit
   function automatic logic cnt_done(input logic [sto_pkg::CNT_W-1:0] cnt,
                                     input logic [sto_pkg::CNT_W-1:0] lim);
      return cnt >= lim;
   endfunction

   // states in which the output stage is powered
   function automatic logic stage_state(input sto_pkg::sto_state_t st);
      return st == sto_pkg::sto_brake_on_s ||
             st == sto_pkg::sto_run_s ||
             st == sto_pkg::sto_brake_off_s;
   endfunction

   // states in which the holding brake is held open
   function automatic logic brake_state(input sto_pkg::sto_state_t st);
      return st == sto_pkg::sto_brake_on_s || st == sto_pkg::sto_run_s;
   endfunction

   // ***********************************************
   // channel filters
   // ***********************************************
   assign chan_in = {torque_off_channel_b, torque_off_channel_a};

   // one loop body serves both channels, so neither one is favoured;
   // a low must outlast the longest test pulse before it is believed
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         flt_cnt_reg[0] <= '0;
         flt_cnt_reg[1] <= '0;
         chan_reg       <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (chan_in[i] == chan_reg[i]) begin
               flt_cnt_reg[i] <= '0;
            end else if (chan_reg[i] &&
                         cnt_done(flt_cnt_reg[i], PULSE_LIM)) begin
               chan_reg[i]    <= 1'b0;
               flt_cnt_reg[i] <= '0;
            end else if (!chan_reg[i] &&
                         cnt_done(flt_cnt_reg[i], ON_LIM)) begin
               chan_reg[i]    <= 1'b1;
               flt_cnt_reg[i] <= '0;
            end else begin
               flt_cnt_reg[i] <= flt_cnt_reg[i] + 1'b1;
            end
         end
      end
   end

   assign both_on = &chan_reg;
   assign any_off = ~both_on; // either channel removes torque

   // ***********************************************
   // discrepancy supervision
   // ***********************************************
   // continuous mismatch only; error sticky until reset since it is fatal
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         disc_cnt_reg <= '0;
         disc_err_reg <= 1'b0;
      end else if (chan_reg[0] == chan_reg[1]) begin
         disc_cnt_reg <= '0;
      end else if (cnt_done(disc_cnt_reg, DISCREP_LIM)) begin
         disc_err_reg <= 1'b1;
      end else begin
         disc_cnt_reg <= disc_cnt_reg + 1'b1;
      end
   end

   // removal while stage live; sticky, cleared only by reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rem_err_reg <= 1'b0;
      end else if (any_off && stage_reg) begin
         rem_err_reg <= 1'b1;
      end
   end

   // ***********************************************
   // restart sequencer
   // ***********************************************
   // removal forces off in one cycle, well inside the sequence bound
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg   <= sto_pkg::sto_off_s;
         seq_cnt_reg <= '0;
      end else if (any_off) begin
         state_reg   <= sto_pkg::sto_off_s;
         seq_cnt_reg <= '0;
      end else begin
         case (state_reg)
            sto_pkg::sto_off_s: begin
               // enable must drop first; relies on far side low time
               if (!drive_enable_input) begin
                  state_reg <= sto_pkg::sto_ready_s;
               end
            end
            sto_pkg::sto_ready_s: begin
               seq_cnt_reg <= '0;
               if (drive_enable_input) begin
                  state_reg <= sto_pkg::sto_start_s;
               end
            end
            sto_pkg::sto_start_s: begin
               if (!drive_enable_input) begin
                  state_reg <= sto_pkg::sto_ready_s;
               end else if (cnt_done(seq_cnt_reg, STAGE_LIM)) begin
                  state_reg   <= sto_pkg::sto_brake_on_s;
                  seq_cnt_reg <= '0;
               end else begin
                  seq_cnt_reg <= seq_cnt_reg + 1'b1;
               end
            end
            sto_pkg::sto_brake_on_s: begin
               if (!drive_enable_input) begin
                  state_reg   <= sto_pkg::sto_brake_off_s;
                  seq_cnt_reg <= '0;
               end else if (cnt_done(seq_cnt_reg, brake_release_cyc)) begin
                  state_reg <= sto_pkg::sto_run_s;
               end else begin
                  seq_cnt_reg <= seq_cnt_reg + 1'b1;
               end
            end
            sto_pkg::sto_run_s: begin
               if (!drive_enable_input) begin
                  state_reg   <= sto_pkg::sto_brake_off_s;
                  seq_cnt_reg <= '0;
               end
            end
            sto_pkg::sto_brake_off_s: begin
               if (cnt_done(seq_cnt_reg, brake_engage_cyc)) begin
                  state_reg   <= sto_pkg::sto_ready_s;
                  seq_cnt_reg <= '0;
               end else begin
                  seq_cnt_reg <= seq_cnt_reg + 1'b1;
               end
            end
            default: begin
               state_reg <= sto_pkg::sto_off_s;
            end
         endcase
      end
   end

   // registered outputs decoded from the current state view, masked by any_off
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stage_reg <= 1'b0;
         brake_reg <= 1'b0;
         setp_reg  <= 1'b0;
      end else begin
         stage_reg <= !any_off && stage_state(state_reg);
         brake_reg <= !any_off && brake_state(state_reg);
         setp_reg  <= !any_off && drive_enable_input &&
                      state_reg == sto_pkg::sto_run_s;
      end
   end

   // ports are the flip-flops themselves, no logic behind them
   assign stage_active      = stage_reg;
   assign brake_released    = brake_reg;
   assign setpoint_enable   = setp_reg;
   assign discrepancy_error = disc_err_reg;
   assign removal_error     = rem_err_reg;
endmodule

/* pkg/sto_pkg.sv */
// safe torque off sequencer constants: timing in microseconds and cycles
// assumes a 25 MHz core clock; all counts derived from the clock rate
package sto_pkg;
   // ***********************************************
   // clock
   // ***********************************************
   localparam int CLK_KHZ          = 25000;
   // ***********************************************
   // times in microseconds, as specified
   // ***********************************************
   localparam int DISCREP_US       = 100000; // tolerated channel mismatch
   localparam int OFF_MAX_US       = 5000;   // longest response to removal
   localparam int ON_MAX_US        = 1000;   // longest recognition of return
   localparam int ON_TYP_US        = 600;    // typical recognition of return
   localparam int SEQ_MAX_US       = 10000;  // internal sequence delay bound
   localparam int ENABLE_LOW_US    = 20000;  // enable low after restore, far
   localparam int PULSE_NOM_US     = 1000;   // test pulse ignored, nominal
   localparam int PULSE_LOW_US     = 500;    // test pulse at lowest supply
   localparam int PULSE_HIGH_US    = 1500;   // test pulse at highest supply
   localparam int STAGE_ON_US      = 6000;   // output stage after enable
   // ***********************************************
   // derived cycle counts
   // ***********************************************
   localparam int DISCREP_CYC  = DISCREP_US * (CLK_KHZ / 1000);
   localparam int PULSE_CYC    = PULSE_HIGH_US * (CLK_KHZ / 1000);
   localparam int ON_CYC       = ON_TYP_US * (CLK_KHZ / 1000);
   localparam int STAGE_ON_CYC = STAGE_ON_US * (CLK_KHZ / 1000);
   localparam int CNT_W        = 32;
   // ***********************************************
   // sequencer states
   // ***********************************************
   typedef enum logic [2:0] {
      sto_off_s,      // torque off, stage inactive
      sto_ready_s,    // channels present, waiting for enable
      sto_start_s,    // stage turning on
      sto_brake_on_s, // brake release delay, setpoint withheld
      sto_run_s,      // setpoint released
      sto_brake_off_s // brake switch-off delay
   } sto_state_t;
endpackage

/* tb/sto_ctrl_model.sv */
// controller model: drives both safety channels and the enable level
// assumes the bench calls its tasks; changes land 2 ns after a rise
`timescale 1ns/1ps
module sto_ctrl_model (
   // clock
   input  wire logic core_clk,
   // driven levels
   output logic      chan_a,
   output logic      chan_b,
   output logic      enable
);
   // ***********************
   // stimulus
   // ***********************
   // all low at time zero: torque off, drive disabled
   initial begin
      chan_a = 1'b0;
      chan_b = 1'b0;
      enable = 1'b0;
   end
   // set levels, hold them n edges, return once outputs have settled
   task automatic drive(input logic a, input logic b, input logic e,
                        input int n);
      @(posedge core_clk);
      #2;
      chan_a = a;
      chan_b = b;
      enable = e;
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // restore channels, keep enable low long enough, then enable
   task automatic restart(input int low_cyc);
      drive(1'b1, 1'b1, 1'b0, low_cyc);
      drive(1'b1, 1'b1, 1'b1, 0);
   endtask
endmodule

/* tb/sto_sequencer_assertions.sv */
// checker: timing relations seen at the sequencer ports
// assumes it is bound into sto_sequencer, one clock domain
`timescale 1ns/1ps
module sto_checker #(
   parameter int DISCREP_CYC  = 200,
   parameter int PULSE_CYC    = 10,
   parameter int STAGE_ON_CYC = 20
) (
   // clock and reset
   input wire logic                      core_clk,
   input wire logic                      resetn,
   // sequencer inputs
   input wire logic                      torque_off_channel_a,
   input wire logic                      torque_off_channel_b,
   input wire logic                      drive_enable_input,
   input wire logic [sto_pkg::CNT_W-1:0] brake_release_cyc,
   input wire logic [sto_pkg::CNT_W-1:0] brake_engage_cyc,
   // sequencer outputs
   input wire logic                      stage_active,
   input wire logic                      brake_released,
   input wire logic                      setpoint_enable,
   input wire logic                      discrepancy_error,
   input wire logic                      removal_error
);
   logic [31:0] lo_n;
   logic [31:0] mis_n;
   logic [31:0] en_n;
   logic [31:0] br_n;
   logic [31:0] bc_n;
   // ***********************
   // run lengths
   // ***********************
   // consecutive cycles of each condition; no wrap within a run
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lo_n <= 32'h0;
         mis_n <= 32'h0;
         en_n <= 32'h0;
         br_n <= 32'h0;
         bc_n <= 32'h0;
      end else begin
         lo_n <= (torque_off_channel_a & torque_off_channel_b) ?
                 32'h0 : lo_n + 32'h1;
         mis_n <= (torque_off_channel_a ^ torque_off_channel_b) ?
                  mis_n + 32'h1 : 32'h0;
         en_n <= drive_enable_input ? en_n + 32'h1 : 32'h0;
         br_n <= brake_released ? br_n + 32'h1 : 32'h0;
         bc_n <= (stage_active & !brake_released) ? bc_n + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_removed_live;
      lo_n == PULSE_CYC + 1 && stage_active;
   endsequence
   a_off_response: assert property (lo_n == PULSE_CYC + 5 |->
      !stage_active && !setpoint_enable) else $error("stage still on");
   a_pulse_ignored: assert property ($past(stage_active) &&
      lo_n inside {[1:PULSE_CYC-2]} && drive_enable_input &&
      $past(drive_enable_input) && !discrepancy_error |-> stage_active)
      else $error("short pulse dropped stage");
   a_removal_flag: assert property (s_removed_live |->
      ##[0:6] removal_error) else $error("no removal error");
   a_errors_sticky: assert property (!$fell(removal_error) &&
      !$fell(discrepancy_error)) else $error("error flag cleared");
   a_discrep_hold: assert property ($rose(discrepancy_error) |->
      mis_n >= DISCREP_CYC - PULSE_CYC) else $error("early mismatch error");
   a_discrep_flag: assert property (mis_n == DISCREP_CYC + 2 * PULSE_CYC + 4
      |-> discrepancy_error) else $error("mismatch not flagged");
   a_stage_delay: assert property ($rose(stage_active) |->
      en_n inside {[STAGE_ON_CYC-1:STAGE_ON_CYC+3]})
      else $error("stage start delay wrong");
   a_setpoint_gate: assert property ($rose(setpoint_enable) |->
      br_n >= brake_release_cyc && stage_active)
      else $error("setpoint before brake delay");
   a_brake_off_delay: assert property ($fell(stage_active) &&
      !drive_enable_input && torque_off_channel_a && torque_off_channel_b
      |-> bc_n >= brake_engage_cyc) else $error("stage off before brake");
endmodule
bind sto_sequencer sto_checker #(.DISCREP_CYC(DISCREP_CYC),
   .PULSE_CYC(PULSE_CYC), .STAGE_ON_CYC(STAGE_ON_CYC)) chk (
   .core_clk(core_clk), .resetn(resetn),
   .torque_off_channel_a(torque_off_channel_a),
   .torque_off_channel_b(torque_off_channel_b),
   .drive_enable_input(drive_enable_input),
   .brake_release_cyc(brake_release_cyc),
   .brake_engage_cyc(brake_engage_cyc), .stage_active(stage_active),
   .brake_released(brake_released), .setpoint_enable(setpoint_enable),
   .discrepancy_error(discrepancy_error), .removal_error(removal_error));

/* tb/test_safe_torque_off_sequencer.sv */
// bench: start, test pulse, removal, restart, stop, abort, mismatch runs
// assumes short counts: pulse 10, return 5, start 20, mismatch 200
`timescale 1ns/1ps
module test_safe_torque_off_sequencer;
   logic                      core_clk;
   logic                      resetn;
   logic                      a;
   logic                      b;
   logic                      en;
   logic [sto_pkg::CNT_W-1:0] rel_cyc;
   logic [sto_pkg::CNT_W-1:0] eng_cyc;
   logic                      stage;
   logic                      brake;
   logic                      setp;
   logic                      derr;
   logic                      rerr;
   int                        failures;
   int                        compares;
   // ***********************
   // clock and parts
   // ***********************
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   sto_ctrl_model ctl (.core_clk(core_clk), .chan_a(a), .chan_b(b),
                       .enable(en));
   sto_sequencer #(.DISCREP_CYC(200), .PULSE_CYC(10), .ON_CYC(5),
      .STAGE_ON_CYC(20)) uut (.core_clk(core_clk), .resetn(resetn),
      .torque_off_channel_a(a), .torque_off_channel_b(b),
      .drive_enable_input(en), .brake_release_cyc(rel_cyc),
      .brake_engage_cyc(eng_cyc), .stage_active(stage),
      .brake_released(brake), .setpoint_enable(setp),
      .discrepancy_error(derr), .removal_error(rerr));
   // ***********************
   // shared tasks
   // ***********************
   task automatic check_bit(input string nm, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask
   // bounded wait on stage (sel high) or setpoint (sel low)
   task automatic wait_out(input logic sel, input logic e, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(posedge core_clk);
         #1;
         if ((sel ? stage : setp) === e) return;
      end
      failures++;
      $display("[ERR] %s expected %b seen %b",
               sel ? "stage_active" : "setpoint_enable", e,
               sel ? stage : setp);
      report_and_stop();
   endtask
   task automatic report_and_stop;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ***********************
   // scenarios
   // ***********************
   task automatic t_start;
      ctl.restart(30);
      wait_out(1'b1, 1'b1, 40);
      check_bit("setpoint_enable", 1'b0, setp);
      wait_out(1'b0, 1'b1, 20);
      check_bit("brake_released", 1'b1, brake);
      $display("start done");
   endtask
   task automatic t_pulse;
      ctl.drive(1'b0, 1'b1, 1'b1, 8);
      ctl.drive(1'b1, 1'b1, 1'b1, 15);
      check_bit("stage_active", 1'b1, stage);
      check_bit("removal_error", 1'b0, rerr);
      $display("pulse done");
   endtask
   // channel b goes first, enable still high: no lead time
   task automatic t_removal;
      ctl.drive(1'b1, 1'b0, 1'b1, 3);
      ctl.drive(1'b0, 1'b0, 1'b1, 20);
      check_bit("stage_active", 1'b0, stage);
      check_bit("removal_error", 1'b1, rerr);
      check_bit("discrepancy_error", 1'b0, derr);
      $display("removal done");
   endtask
   task automatic t_stop;
      ctl.drive(1'b1, 1'b1, 1'b0, 2);
      check_bit("setpoint_enable", 1'b0, setp);
      check_bit("stage_active", 1'b1, stage);
      wait_out(1'b1, 1'b0, 20);
      $display("stop done");
   endtask
   // enable dropped inside the brake release delay: stop path still taken
   task automatic t_abort;
      ctl.drive(1'b1, 1'b1, 1'b1, 22);
      check_bit("stage_active", 1'b1, stage);
      ctl.drive(1'b1, 1'b1, 1'b0, 2);
      check_bit("setpoint_enable", 1'b0, setp);
      check_bit("brake_released", 1'b0, brake);
      check_bit("stage_active", 1'b1, stage);
      wait_out(1'b1, 1'b0, 20);
      $display("abort done");
   endtask
   task automatic t_discrep;
      ctl.drive(1'b0, 1'b1, 1'b0, 150);
      ctl.drive(1'b1, 1'b1, 1'b0, 20);
      ctl.drive(1'b1, 1'b0, 1'b0, 150);
      ctl.drive(1'b1, 1'b1, 1'b0, 20);
      check_bit("discrepancy_error", 1'b0, derr);
      ctl.drive(1'b0, 1'b1, 1'b0, 260);
      check_bit("discrepancy_error", 1'b1, derr);
      $display("mismatch done");
   endtask
   // main sequence; restart after removal follows the enable-low rule
   initial begin
      failures = 0;
      compares = 0;
      resetn = 1'b0;
      rel_cyc = 32'h6;
      eng_cyc = 32'h4;
      repeat (2) @(posedge core_clk);
      #2;
      resetn = 1'b1;
      t_start();
      t_pulse();
      t_removal();
      t_start();
      t_stop();
      t_abort();
      t_discrep();
      report_and_stop();
   end
endmodule
